// ===== verilog/ucn_pkg.sv
// ucn_pkg: build-time configuration, divider constants and state layout
// for the transceiver user clock network.
// assumes: sources sampled on sys_clk; all settings fixed at build time.
`default_nettype none

package ucn_pkg;

    // ------------------------------------------------------------------
    // build-time configuration
    // ------------------------------------------------------------------
    localparam int         NUM_CHANNELS       = 4;
    localparam int         MASTER_CHANNEL     = 0;
    localparam int         TX_USER_WIDTH      = 64;
    localparam int         TX_INTERNAL_WIDTH  = 32;
    localparam int         RX_USER_WIDTH      = 32;
    localparam int         RX_INTERNAL_WIDTH  = 32;
    localparam bit         RX_SINGLE_LANE_BYP = 1'b0;
    localparam bit         RX_CDR_GATE        = 1'b1;

    // ------------------------------------------------------------------
    // divide ratios, derived once from the widths
    // ------------------------------------------------------------------
    localparam int         CNT_W       = 8;
    localparam bit         TX_TWO_BUF  = (TX_USER_WIDTH > TX_INTERNAL_WIDTH);
    localparam bit         RX_TWO_BUF  = (RX_USER_WIDTH > RX_INTERNAL_WIDTH);
    localparam logic [7:0] TX_LANE_DIV = 8'h01;
    localparam logic [7:0] RX_LANE_DIV = 8'h01;
    localparam logic [7:0] TX_IF_DIV   = TX_TWO_BUF ? 8'h02 : TX_LANE_DIV;
    localparam logic [7:0] RX_IF_DIV   = RX_TWO_BUF ? 8'h02 : RX_LANE_DIV;
    localparam int         RX_NETS     = RX_SINGLE_LANE_BYP ? NUM_CHANNELS : 1;

    // ------------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------------
    localparam logic [7:0] CNT_RESET   = 8'h00;

    // ------------------------------------------------------------------
    // whole state of the clock network
    // ------------------------------------------------------------------
    typedef struct packed {
        logic                           txSrcPrev;
        logic                           txSrcCopy;
        logic [CNT_W-1:0]               txLaneCnt;
        logic [CNT_W-1:0]               txIfCnt;
        logic                           txLaneClk;
        logic                           txIfClk;
        logic                           txActive;
        logic [RX_NETS-1:0]             rxSrcPrev;
        logic [RX_NETS-1:0]             rxSrcCopy;
        logic [RX_NETS-1:0][CNT_W-1:0]  rxLaneCnt;
        logic [RX_NETS-1:0][CNT_W-1:0]  rxIfCnt;
        logic [RX_NETS-1:0]             rxLaneClk;
        logic [RX_NETS-1:0]             rxIfClk;
        logic [RX_NETS-1:0]             rxActive;
    } ucn_state_s;

endpackage

`default_nettype wire

// ===== verilog/ucn_user_clock_network.sv
// ucn_user_clock_network: transmit and receive user clock networks.
// assumes: channel output clocks are synchronous levels sampled on sys_clk
// at least twice per period; dividing buffers are modelled as counters.
`default_nettype none

// Notes on behaviour
// - one transmit network serves every channel
// - transmit source is master channel output clock
// - narrow transmit width: one buffer, both clocks
// - wide transmit width: lane clock twice interface
// - second transmit buffer drives every interface clock
// - generated clocks wired to every served channel
// - reset input holds all dividing buffers reset
// - active indicator asserts synchronously after release
// - source clock also exposed on boundary
// - generated clocks also exposed on boundary
// - channel clock ports exposed when network outside
// - one receive network, or one per bypassed lane
// - receive source is master or own channel
// - narrow receive width: one buffer, both clocks
// - wide receive width: lane twice interface rate
// - receive buffers drive matching channel inputs
// - recovery not stable holds receive network reset
// - active indicators go to reset controller
module ucn_user_clock_network
    import ucn_pkg::*;
(
    input  wire logic                    sys_clk,
    input  wire logic                    rst,
    input  wire logic                    ce,
    input  wire logic [NUM_CHANNELS-1:0] txChannelOutputClock,
    input  wire logic                    txClockReset,
    input  wire logic [NUM_CHANNELS-1:0] rxChannelOutputClock,
    input  wire logic [NUM_CHANNELS-1:0] rxClockReset,
    input  wire logic                    rxCdrStable,
    output logic      [NUM_CHANNELS-1:0] txLaneClock,
    output logic      [NUM_CHANNELS-1:0] txInterfaceClock,
    output logic                         txSourceClockOut,
    output logic                         txLaneClockOut,
    output logic                         txInterfaceClockOut,
    output logic                         txActiveToResetCtl,
    output logic      [NUM_CHANNELS-1:0] rxLaneClock,
    output logic      [NUM_CHANNELS-1:0] rxInterfaceClock,
    output logic      [RX_NETS-1:0]      rxSourceClockOut,
    output logic      [RX_NETS-1:0]      rxLaneClockOut,
    output logic      [RX_NETS-1:0]      rxInterfaceClockOut,
    output logic      [RX_NETS-1:0]      rxActiveToResetCtl
);

    // ------------------------------------------------------------------
    // divider helpers
    // ------------------------------------------------------------------
    // counter step on each source rising edge; ratio is a constant
    function automatic logic [CNT_W-1:0] divNext(
        input logic [CNT_W-1:0] cnt,
        input logic [7:0]       div,
        input logic             rise
    );
        logic [CNT_W-1:0] res;
        res = cnt;
        if (rise) begin
            res = (cnt >= div - 8'h01) ? CNT_RESET : cnt + 8'h01;
        end
        return res;
    endfunction

    // output level: ratio one passes the source, else high from the
    // first counted source rise for half the ratio; a count of zero
    // right after release stays low so no edge precedes the source
    function automatic logic divLevel(
        input logic [CNT_W-1:0] cnt,
        input logic [7:0]       div,
        input logic             src
    );
        logic res;
        res = (div == 8'h01) ? src
            : ((cnt != CNT_RESET) && (cnt <= (div >> 1)));
        return res;
    endfunction

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    ucn_state_s          state_reg;
    ucn_state_s          state_next;
    logic                txHold;
    logic [RX_NETS-1:0]  rxHold;
    logic [RX_NETS-1:0]  rxSrc;

    // cdr gate keeps the receive network reset until recovery settles
    always_comb begin
        txHold = txClockReset;
        for (int n = 0; n < RX_NETS; n++) begin
            // shared net takes the master, bypassed lanes their own
            rxSrc[n]  = RX_SINGLE_LANE_BYP ? rxChannelOutputClock[n]
                                           : rxChannelOutputClock[MASTER_CHANNEL];
            rxHold[n] = rxClockReset[n]
                      | (RX_CDR_GATE & ~rxCdrStable);
        end
    end

    // ------------------------------------------------------------------
    // next-state logic
    // ------------------------------------------------------------------
    always_comb begin
        logic                txSrc;
        logic                txRise;
        logic                rise;
        logic [CNT_W-1:0]    laneCnt;
        logic [CNT_W-1:0]    ifCnt;
        txSrc      = txChannelOutputClock[MASTER_CHANNEL];
        txRise     = 1'b0;
        rise       = 1'b0;
        laneCnt    = CNT_RESET;
        ifCnt      = CNT_RESET;
        state_next = state_reg;
        if (ce) begin
            // transmit network, a single instance for all channels
            state_next.txSrcPrev = txSrc;
            state_next.txSrcCopy = txSrc;
            txRise  = txSrc & ~state_reg.txSrcPrev;
            laneCnt = divNext(state_reg.txLaneCnt, TX_LANE_DIV, txRise);
            ifCnt   = divNext(state_reg.txIfCnt, TX_IF_DIV, txRise);
            if (txHold) begin
                state_next.txLaneCnt = CNT_RESET;
                state_next.txIfCnt   = CNT_RESET;
                state_next.txLaneClk = 1'b0;
                state_next.txIfClk   = 1'b0;
                state_next.txActive  = 1'b0;
            end else begin
                state_next.txLaneCnt = laneCnt;
                state_next.txIfCnt   = ifCnt;
                state_next.txLaneClk = divLevel(laneCnt, TX_LANE_DIV, txSrc);
                // one buffer: interface copies lane; two: own ratio
                state_next.txIfClk   = TX_TWO_BUF
                    ? divLevel(ifCnt, TX_IF_DIV, txSrc)
                    : divLevel(laneCnt, TX_LANE_DIV, txSrc);
                // active follows the first interface clock high
                state_next.txActive  = state_reg.txActive
                                     | state_reg.txIfClk;
            end
            // receive networks, one or one per bypassed lane
            for (int n = 0; n < RX_NETS; n++) begin
                state_next.rxSrcPrev[n] = rxSrc[n];
                state_next.rxSrcCopy[n] = rxSrc[n];
                rise    = rxSrc[n] & ~state_reg.rxSrcPrev[n];
                laneCnt = divNext(state_reg.rxLaneCnt[n], RX_LANE_DIV, rise);
                ifCnt   = divNext(state_reg.rxIfCnt[n], RX_IF_DIV, rise);
                if (rxHold[n]) begin
                    state_next.rxLaneCnt[n] = CNT_RESET;
                    state_next.rxIfCnt[n]   = CNT_RESET;
                    state_next.rxLaneClk[n] = 1'b0;
                    state_next.rxIfClk[n]   = 1'b0;
                    state_next.rxActive[n]  = 1'b0;
                end else begin
                    state_next.rxLaneCnt[n] = laneCnt;
                    state_next.rxIfCnt[n]   = ifCnt;
                    state_next.rxLaneClk[n] =
                        divLevel(laneCnt, RX_LANE_DIV, rxSrc[n]);
                    state_next.rxIfClk[n]   = RX_TWO_BUF
                        ? divLevel(ifCnt, RX_IF_DIV, rxSrc[n])
                        : divLevel(laneCnt, RX_LANE_DIV, rxSrc[n]);
                    state_next.rxActive[n]  = state_reg.rxActive[n]
                                            | state_reg.rxIfClk[n];
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // state register
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    // ------------------------------------------------------------------
    // outputs: channel fan-out and boundary copies
    // ------------------------------------------------------------------
    always_comb begin
        for (int c = 0; c < NUM_CHANNELS; c++) begin
            // every channel gets the single transmit network
            txLaneClock[c]      = state_reg.txLaneClk;
            txInterfaceClock[c] = state_reg.txIfClk;
            rxLaneClock[c]      = state_reg.rxLaneClk[RX_SINGLE_LANE_BYP ? c : 0];
            rxInterfaceClock[c] = state_reg.rxIfClk[RX_SINGLE_LANE_BYP ? c : 0];
        end
    end

    // boundary copies serve both placements of the network
    assign txSourceClockOut    = state_reg.txSrcCopy;
    assign txLaneClockOut      = state_reg.txLaneClk;
    assign txInterfaceClockOut = state_reg.txIfClk;
    assign txActiveToResetCtl  = state_reg.txActive;
    assign rxSourceClockOut    = state_reg.rxSrcCopy;
    assign rxLaneClockOut      = state_reg.rxLaneClk;
    assign rxInterfaceClockOut = state_reg.rxIfClk;
    assign rxActiveToResetCtl  = state_reg.rxActive;

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    a_tx_hold_clocks: assert property (
        ce && txHold |=> !txLaneClockOut && !txInterfaceClockOut
                         && !txActiveToResetCtl)
        else $error("tx clocks or active not held in reset");

    a_tx_active_rise: assert property (
        ce && !txHold && txInterfaceClockOut |=> txActiveToResetCtl)
        else $error("tx active missed first interface high");

    a_tx_active_early: assert property (
        $rose(txActiveToResetCtl) |-> $past(txInterfaceClockOut))
        else $error("tx active rose before interface clock");

    a_tx_one_buffer: assert property (
        TX_TWO_BUF || (txLaneClockOut == txInterfaceClockOut))
        else $error("tx single buffer clocks differ");

    a_tx_two_ratio: assert property (
        TX_TWO_BUF && $rose(txInterfaceClockOut) |-> $rose(txLaneClockOut))
        else $error("tx interface edge not aligned to lane edge");

    a_tx_src_copy: assert property (
        ce |=> txSourceClockOut == $past(txChannelOutputClock[MASTER_CHANNEL]))
        else $error("tx source copy wrong");

    a_tx_fanout: assert property (
        txLaneClock == {NUM_CHANNELS{txLaneClockOut}}
        && txInterfaceClock == {NUM_CHANNELS{txInterfaceClockOut}})
        else $error("tx channel fan-out mismatch");

    a_rx_cdr_hold: assert property (
        ce && RX_CDR_GATE && !rxCdrStable |=> !rxActiveToResetCtl[0]
                                              && !rxLaneClockOut[0])
        else $error("rx network ran before recovery stable");

    a_rx_one_buffer: assert property (
        RX_TWO_BUF || (rxLaneClockOut[0] == rxInterfaceClockOut[0]))
        else $error("rx single buffer clocks differ");

    a_rx_active_rise: assert property (
        ce && !rxHold[0] && rxInterfaceClockOut[0]
        |=> rxActiveToResetCtl[0])
        else $error("rx active missed first interface high");

endmodule

`default_nettype wire

// ===== testbench/ucn_channel_model.sv
// ucn_channel_model: channel output clocks seen by the clock network.
// assumes: driven on falling sys_clk edges; master stands low, other channels high, while run is low.
`default_nettype none

module ucn_channel_model
    import ucn_pkg::*;
(
    input  wire logic                    sys_clk,
    input  wire logic                    run,
    input  wire logic [3:0]              halfPeriod,
    output logic      [NUM_CHANNELS-1:0] tx_channel_output_clock,
    output logic      [NUM_CHANNELS-1:0] rx_channel_output_clock
);
    timeunit 1ns;
    timeprecision 1ps;

    logic lvl = 1'b0;
    int   cnt = 0;

    // high and low for at least one cycle each, still outside frames
    always @(negedge sys_clk) begin
        if (!run) begin
            lvl <= 1'b0;
            cnt <= 0;
        end else if (cnt + 1 >= int'(halfPeriod)) begin
            lvl <= ~lvl;
            cnt <= 0;
        end else begin
            cnt <= cnt + 1;
        end
    end

    // other channels carry the inverse so a wrong source pick shows
    always_comb begin
        tx_channel_output_clock                 = {NUM_CHANNELS{~lvl}};
        tx_channel_output_clock[MASTER_CHANNEL] = lvl;
        rx_channel_output_clock                 = {NUM_CHANNELS{~lvl}};
        rx_channel_output_clock[MASTER_CHANNEL] = lvl;
    end
endmodule

`default_nettype wire

// ===== testbench/ucn_user_clock_network_tb.sv
// ucn_user_clock_network_tb: self-checking bench for the clock network.
// assumes: default package settings (two tx buffers, one shared rx net).
`default_nettype none

module ucn_user_clock_network_tb;
    import ucn_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;

    logic sys_clk = 1'b0, rst = 1'b1, ce = 1'b1, run = 1'b0;
    logic txClockReset = 1'b1, rxCdrStable = 1'b0;
    logic [3:0] halfPeriod = 4'h1;
    logic [NUM_CHANNELS-1:0] rxClockReset = '1, txSrc, rxSrc;
    logic [NUM_CHANNELS-1:0] txLane, txIf, rxLane, rxIf;
    logic txSrcOut, txLaneOut, txIfOut, txActive;
    logic [RX_NETS-1:0] rxSrcOut, rxLaneOut, rxIfOut, rxActive;
    int failCount = 0, nCompared = 0;
    int rise [5] = '{default: 0};
    int base [5];
    logic [4:0] prevLvl = 5'h00;
    logic [4:0] curLvl;

    assign curLvl = {rxIfOut[0], rxLaneOut[0], txSrcOut, txIfOut, txLaneOut};

    typedef struct {logic [3:0] half; int per, expLane, expIf;} ucn_row_s;
    ucn_row_s rows [3] = '{'{4'h1, 4, 4, 2}, '{4'h2, 5, 5, 3},
                          '{4'h3, 3, 3, 2}};

    initial forever #2 sys_clk = ~sys_clk;

    ucn_channel_model u_chan (.sys_clk(sys_clk), .run(run),
        .halfPeriod(halfPeriod), .tx_channel_output_clock(txSrc), .rx_channel_output_clock(rxSrc));

    ucn_user_clock_network u_dut (.sys_clk(sys_clk), .rst(rst), .ce(ce),
        .txChannelOutputClock(txSrc), .txClockReset(txClockReset),
        .rxChannelOutputClock(rxSrc), .rxClockReset(rxClockReset),
        .rxCdrStable(rxCdrStable), .txLaneClock(txLane),
        .txInterfaceClock(txIf), .txSourceClockOut(txSrcOut),
        .txLaneClockOut(txLaneOut), .txInterfaceClockOut(txIfOut),
        .txActiveToResetCtl(txActive), .rxLaneClock(rxLane),
        .rxInterfaceClock(rxIf), .rxSourceClockOut(rxSrcOut),
        .rxLaneClockOut(rxLaneOut), .rxInterfaceClockOut(rxIfOut),
        .rxActiveToResetCtl(rxActive));

    // ------------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------------
    task automatic check(input string what, input logic [7:0] exp,
                         input logic [7:0] got);
        nCompared++;
        if (got !== exp) begin
            failCount++;
            $display("CHECK FAILED %s expected %0h seen %0h", what, exp, got);
        end
    endtask

    task automatic completeRun();
        if (failCount == 0 && nCompared > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic cycles(input int n);
        repeat (n) @(negedge sys_clk);
    endtask

    // ------------------------------------------------------------------
    // monitor: fan-out copies and rising-edge counts
    // ------------------------------------------------------------------
    always @(negedge sys_clk) begin
        if (!rst) begin
            check("txLaneFan", {4'h0, {4{txLaneOut}}}, {4'h0, txLane});
            check("txIfFan", {4'h0, {4{txIfOut}}}, {4'h0, txIf});
            check("rxLaneFan", {4'h0, {4{rxLaneOut[0]}}}, {4'h0, rxLane});
            check("rxIfEqLane", {7'h00, rxLaneOut[0]}, {7'h00, rxIfOut[0]});
        end
        for (int i = 0; i < 5; i++) begin
            if (curLvl[i] && !prevLvl[i]) begin
                rise[i]++;
            end
        end
        prevLvl <= curLvl;
    end

    // ------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------
    initial begin
        cycles(4);
        rst = 1'b0;
        foreach (rows[r]) begin
            txClockReset = 1'b1;
            rxClockReset = '1;
            cycles(4);
            check("activeHeld", 8'h00, {6'h00, rxActive[0], txActive});
            txClockReset = 1'b0;
            rxClockReset = '0;
            rxCdrStable = 1'b1;
            halfPeriod = rows[r].half;
            base = rise;
            run = 1'b1;
            cycles(2 * rows[r].half * rows[r].per);
            run = 1'b0;
            cycles(4);
            check("txLaneRises", 8'(rows[r].expLane), 8'(rise[0] - base[0]));
            check("txIfRises", 8'(rows[r].expIf), 8'(rise[1] - base[1]));
            check("txSrcRises", 8'(rows[r].per), 8'(rise[2] - base[2]));
            check("rxLaneRises", 8'(rows[r].per), 8'(rise[3] - base[3]));
            check("rxIfRises", 8'(rows[r].per), 8'(rise[4] - base[4]));
            check("activeUp", 8'h03, {6'h00, rxActive[0], txActive});
        end
        // hold reasserted mid-run drops clocks and active
        halfPeriod = 4'h1;
        run = 1'b1;
        cycles(4);
        txClockReset = 1'b1;
        rxCdrStable = 1'b0;
        cycles(3);
        check("holdDrop", 8'h00, {5'h00, txLaneOut, txIfOut, txActive});
        check("cdrGate", 8'h00, {7'h00, rxActive[0]});
        // freeze with clock enable low
        txClockReset = 1'b0;
        rxCdrStable = 1'b1;
        cycles(8);
        ce = 1'b0;
        cycles(1);
        base = rise;
        cycles(8);
        check("ceFreeze", 8'h00, 8'(rise[0] - base[0]));
        check("ceActive", 8'h03, {6'h00, rxActive[0], txActive});
        ce = 1'b1;
        // synchronous reset in mid-run clears every output
        rst = 1'b1;
        cycles(2);
        check("rstTx", 8'h00, {4'h0, txSrcOut, txLaneOut, txIfOut, txActive});
        check("rstRx", 8'h00, {4'h0, rxSrcOut[0], rxLaneOut[0], rxIfOut[0],
                               rxActive[0]});
        rst = 1'b0;
        run = 1'b0;
        cycles(4);
        completeRun();
    end

    initial begin
        #20000;
        failCount++;
        completeRun();
    end
endmodule

`default_nettype wire
